// >>> include/ssp_pkg.sv
`default_nettype none
package ssp_pkg;
  localparam int unsigned NPORT = 2;
  localparam int unsigned NSEC = 4;
  localparam int unsigned AW = 6;
  localparam int unsigned DW = 32;
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_SCLKDIV = 6'h01;
  localparam logic [5:0] OFF_FSDIV = 6'h02;
  localparam logic [5:0] OFF_TXD = 6'h03;
  localparam logic [5:0] OFF_RXD = 6'h04;
  localparam logic [5:0] OFF_ABUF = 6'h05;
  localparam logic [5:0] PORT_STRIDE = 6'h08;
  localparam logic [5:0] OFF_SYSCTL = 6'h10;
  localparam logic [5:0] OFF_STAT = 6'h11;
  localparam logic [5:0] OFF_MASK = 6'h12;
  localparam logic [5:0] OFF_MCH_RX = 6'h13;
  localparam logic [5:0] OFF_MCH_TX = 6'h14;
  localparam logic [5:0] OFF_FLAG = 6'h15;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [15:0] SCLKDIV_RST = 16'h0003;
  localparam logic [15:0] FSDIV_RST = 16'h001F;
  localparam logic [15:0] ABUF_RST = 16'h0000;
  localparam logic [31:0] MCH_RST = 32'h00000000;
  localparam logic [1:0] CMP_MU = 2'h2;
  localparam logic [1:0] CMP_A = 2'h3;
  localparam logic [3:0] SLEN_MIN = 4'h2;
  localparam logic [3:0] SLEN_CMP = 4'h7;
  localparam logic [4:0] MC_LAST_24 = 5'h17;
  localparam logic [4:0] MC_LAST_32 = 5'h1F;
  localparam int unsigned ST_IRQA = 4;
  localparam int unsigned ST_IRQB = 5;
  localparam int unsigned ST_W = 6;
  localparam logic [ST_W-1:0] STAT_RST = 6'h00;
  localparam logic [ST_W-1:0] MASK_RST = 6'h00;
  localparam int unsigned FLG_OUT = 0;
  localparam int unsigned FLG_IN = 1;
  localparam int unsigned FLG_TXF = 2;
  localparam int unsigned FLG_RXF = 4;

  typedef enum logic {SEC_IDLE, SEC_SHIFT} ssp_sec_state_t;

  // index [0] is the receive section, [1] the transmit section
  typedef struct packed {
    logic [7:0] rsvd;
    logic ab_tx;
    logic ab_rx;
    logic mc32;
    logic mce;
    logic [1:0][1:0] cmp;
    logic [1:0] late;
    logic [1:0] wide;
    logic [1:0] inv;
    logic [1:0] ifs;
    logic [1:0] fen;
    logic iclk;
    logic en;
    logic [3:0] slen;
  } ssp_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } ssp_bus_req_t;

  typedef struct packed {
    logic sclk;
    logic rfs;
    logic tfs;
    logic dr;
  } ssp_pin_in_t;

  typedef struct packed {
    logic sclk;
    logic sclk_oe_n;
    logic rfs;
    logic rfs_oe_n;
    logic tfs;
    logic tfs_oe_n;
    logic dt;
    logic dt_oe_n;
  } ssp_pin_out_t;
endpackage
`default_nettype wire

// >>> logic/ssp_sync.sv
`default_nettype none
module ssp_sync #(
  parameter int unsigned W = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> logic/ssp_port_pair.sv
`default_nettype none
// Contract
// R01 - separate double-buffered receive and transmit sections
// R02 - serial clock internal divider or external
// R03 - receive and transmit framing configured independently
// R04 - frameless, internal or external frame sync
// R05 - frame sync polarity selectable
// R06 - two frame widths and two timings
// R07 - word length from 3 to 16 bits
// R08 - optional A-law or mu-law companding
// R09 - distinct interrupt per section per word
// R10 - autobuffer moves circular buffer, one cycle/word
// R11 - autobuffer interrupts after whole buffer
// R12 - first port multichannel 24 or 32 slots
// R13 - second port pins become two interrupts
// R14 - second port data pins become flags
// R15 - internal clock output kept in flag mode
// R16 - pin function changeable any time
// R17 - serial traffic never stalls the core
// R18 - system control bit selects second port mode
// R19 - external clock and frame synchronised first
module ssp_port_pair
  import ssp_pkg::*;
#(
  parameter int unsigned DIV_W = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire ssp_bus_req_t bus_req,
  output logic [DW-1:0] rd_data_q,
  input wire ssp_pin_in_t [NPORT-1:0] pin_in,
  output ssp_pin_out_t [NPORT-1:0] pin_out_q,
  output logic irq_q,
  output logic [NSEC-1:0] abuf_req_q
);
  if (DIV_W < 2 || DIV_W > 16) begin : g_chk
    $error("DIV_W must lie between 2 and 16");
  end

  function automatic logic hit(input logic [AW-1:0] a, input int unsigned p,
                               input logic [AW-1:0] off);
    return a == AW'(p * 32'(PORT_STRIDE) + 32'(off));
  endfunction

  function automatic logic [15:0] wmask(input logic [3:0] n);
    return 16'((32'h2 << n) - 32'h1);
  endfunction

  function automatic logic is_cmp(input logic [1:0] c);
    return c == CMP_MU || c == CMP_A;
  endfunction

  function automatic logic [3:0] eff_len(input ssp_ctrl_t c, input int unsigned d);
    if (is_cmp(c.cmp[d])) begin
      return SLEN_CMP;
    end
    return (c.slen < SLEN_MIN) ? SLEN_MIN : c.slen;
  endfunction

  // linear 16-bit to 8-bit code
  function automatic logic [7:0] enc(input logic [15:0] x, input logic alaw);
    logic s;
    logic [13:0] m;
    logic [11:0] a;
    logic [2:0] seg;
    logic [3:0] man;
    s = x[15];
    m = s ? ~x[15:2] : x[15:2];
    a = m[12:1];
    seg = 3'h0;
    if (alaw) begin
      for (int i = 0; i < 7; i++) begin
        if (a[i + 5]) seg = 3'(i + 1);
      end
      man = 4'(a >> ((seg == 3'h0) ? 3'h1 : seg));
      return {!s, seg, man} ^ 8'h55;
    end
    if (m > 14'h1FDE) m = 14'h1FDE;
    m = m + 14'h0021;
    for (int i = 0; i < 8; i++) begin
      if (m[i + 5]) seg = 3'(i);
    end
    man = 4'(m >> (4'(seg) + 4'h1));
    return ~{s, seg, man};
  endfunction

  // 8-bit code to linear 16-bit
  function automatic logic [15:0] dec(input logic [7:0] c, input logic alaw);
    logic [7:0] u;
    logic [15:0] t;
    logic neg;
    if (alaw) begin
      u = c ^ 8'h55;
      neg = !u[7];
      t = {8'h00, u[3:0], 4'h8};
      if (u[6:4] != 3'h0) t = (t + 16'h0100) << (u[6:4] - 3'h1);
    end else begin
      u = ~c;
      neg = u[7];
      t = ({9'h000, u[3:0], 3'h0} + 16'h0084) << u[6:4];
      t = t - 16'h0084;
    end
    return neg ? (16'h0000 - t) : t;
  endfunction

  ssp_ctrl_t ctrl_q [NPORT];
  logic [DIV_W-1:0] sclkdiv_q [NPORT];
  logic [15:0] fsdiv_q [NPORT];
  logic [15:0] abuf_q [NPORT];
  logic alt_q;
  logic flag_out_q;
  logic [ST_W-1:0] stat_q;
  logic [ST_W-1:0] mask_q;
  logic [31:0] mch_rx_q;
  logic [31:0] mch_tx_q;
  logic [1:0] ext_prev_q;
  logic [1:0] ext_ev_q;
  logic [DW-1:0] rd_mux;
  logic [4*NPORT-1:0] pin_raw;
  logic [4*NPORT-1:0] pin_sy;
  ssp_pin_in_t sy [NPORT];
  logic [NPORT-1:0] rise;
  logic [NPORT-1:0] fall;
  logic [NPORT-1:0] frame_due;
  logic [NPORT-1:0] rx_start;
  logic [NSEC-1:0] sec_ev;
  logic [NSEC-1:0] sec_full;
  logic [NSEC-1:0] fs_gen;
  logic [NSEC-1:0] dt_bit;
  logic [NSEC-1:0] dt_drv;
  logic [15:0] hold [NSEC];

  ssp_sync #(
    .W(4 * NPORT)
  ) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .d(pin_raw),
    .q(pin_sy)
  );

  // register writes take effect at once, whatever the port is doing
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int p = 0; p < NPORT; p++) begin
        ctrl_q[p] <= ssp_ctrl_t'(CTRL_RST);
        sclkdiv_q[p] <= DIV_W'(SCLKDIV_RST);
        fsdiv_q[p] <= FSDIV_RST;
        abuf_q[p] <= ABUF_RST;
      end
      alt_q <= 1'b0;
      flag_out_q <= 1'b0;
      mask_q <= MASK_RST;
      mch_rx_q <= MCH_RST;
      mch_tx_q <= MCH_RST;
    end else if (bus_req.wr) begin
      for (int p = 0; p < NPORT; p++) begin
        if (hit(bus_req.addr, p, OFF_CTRL)) begin
          ctrl_q[p] <= ssp_ctrl_t'(bus_req.wdata); // R16
        end else if (hit(bus_req.addr, p, OFF_SCLKDIV)) begin
          sclkdiv_q[p] <= bus_req.wdata[DIV_W-1:0];
        end else if (hit(bus_req.addr, p, OFF_FSDIV)) begin
          fsdiv_q[p] <= bus_req.wdata[15:0];
        end else if (hit(bus_req.addr, p, OFF_ABUF)) begin
          abuf_q[p] <= bus_req.wdata[15:0];
        end
      end
      if (bus_req.addr == OFF_SYSCTL) begin
        alt_q <= bus_req.wdata[0]; // R18
      end else if (bus_req.addr == OFF_MASK) begin
        mask_q <= bus_req.wdata[ST_W-1:0];
      end else if (bus_req.addr == OFF_MCH_RX) begin
        mch_rx_q <= bus_req.wdata;
      end else if (bus_req.addr == OFF_MCH_TX) begin
        mch_tx_q <= bus_req.wdata;
      end else if (bus_req.addr == OFF_FLAG) begin
        flag_out_q <= bus_req.wdata[FLG_OUT]; // R14
      end
    end
  end

  // sticky status, write one to clear, a new event wins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stat_q <= STAT_RST;
      irq_q <= 1'b0;
    end else begin
      if (bus_req.wr && bus_req.addr == OFF_STAT) begin
        stat_q <= (stat_q & ~bus_req.wdata[ST_W-1:0]) | {ext_ev_q, sec_ev}; // R09
      end else begin
        stat_q <= stat_q | {ext_ev_q, sec_ev}; // R09
      end
      irq_q <= |(stat_q & mask_q);
    end
  end

  // falling edges on the second port's frame pins become interrupts
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ext_prev_q <= 2'h3;
      ext_ev_q <= 2'h0;
    end else begin
      ext_prev_q <= {sy[1].tfs, sy[1].rfs};
      ext_ev_q <= {2{alt_q}} & ext_prev_q & ~{sy[1].tfs, sy[1].rfs}; // R13
    end
  end

  always_comb begin
    rd_mux = '0;
    for (int p = 0; p < NPORT; p++) begin
      if (hit(bus_req.addr, p, OFF_CTRL)) begin
        rd_mux = ctrl_q[p];
      end else if (hit(bus_req.addr, p, OFF_SCLKDIV)) begin
        rd_mux = 32'(sclkdiv_q[p]);
      end else if (hit(bus_req.addr, p, OFF_FSDIV)) begin
        rd_mux = 32'(fsdiv_q[p]);
      end else if (hit(bus_req.addr, p, OFF_TXD)) begin
        rd_mux = 32'(hold[2 * p + 1]);
      end else if (hit(bus_req.addr, p, OFF_RXD)) begin
        rd_mux = 32'(hold[2 * p]);
      end else if (hit(bus_req.addr, p, OFF_ABUF)) begin
        rd_mux = 32'(abuf_q[p]);
      end
    end
    if (bus_req.addr == OFF_SYSCTL) begin
      rd_mux = 32'(alt_q);
    end else if (bus_req.addr == OFF_STAT) begin
      rd_mux = 32'(stat_q);
    end else if (bus_req.addr == OFF_MASK) begin
      rd_mux = 32'(mask_q);
    end else if (bus_req.addr == OFF_MCH_RX) begin
      rd_mux = mch_rx_q;
    end else if (bus_req.addr == OFF_MCH_TX) begin
      rd_mux = mch_tx_q;
    end else if (bus_req.addr == OFF_FLAG) begin
      rd_mux[FLG_OUT] = flag_out_q;
      rd_mux[FLG_IN] = sy[1].dr; // R14
      rd_mux[FLG_TXF +: 2] = {sec_full[3], sec_full[1]};
      rd_mux[FLG_RXF +: 2] = {sec_full[2], sec_full[0]};
    end
  end

  // answer always one cycle later, the core never waits
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= bus_req.rd ? rd_mux : '0; // R17
    end
  end

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic [DIV_W-1:0] div_q;
    logic sclk_int_q;
    logic sclk_prev_q;
    logic [15:0] fcnt_q;
    logic due_q;
    logic tog;
    ssp_pin_out_t po_q;

    assign pin_raw[4 * p +: 4] = pin_in[p];
    assign sy[p] = pin_sy[4 * p +: 4]; // R19
    assign tog = ctrl_q[p].iclk && div_q == sclkdiv_q[p];
    assign rise[p] = ctrl_q[p].iclk ? (tog && !sclk_int_q) : (sy[p].sclk && !sclk_prev_q); // R02
    assign fall[p] = ctrl_q[p].iclk ? (tog && sclk_int_q) : (!sy[p].sclk && sclk_prev_q); // R02
    assign frame_due[p] = due_q;
    assign pin_out_q[p] = po_q;

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        div_q <= '0;
        sclk_int_q <= 1'b0;
        sclk_prev_q <= 1'b0;
      end else begin
        sclk_prev_q <= sy[p].sclk; // R19
        if (!ctrl_q[p].iclk || tog) begin
          div_q <= '0;
        end else begin
          div_q <= div_q + 1'b1;
        end
        if (tog) begin
          sclk_int_q <= !sclk_int_q; // R02
        end
      end
    end

    // periodic receive frame request for internally generated frames
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        fcnt_q <= '0;
        due_q <= 1'b0;
      end else begin
        if (fall[p] && fcnt_q == fsdiv_q[p]) begin
          fcnt_q <= '0;
          due_q <= 1'b1;
        end else begin
          if (fall[p]) fcnt_q <= fcnt_q + 16'h0001;
          if (rx_start[p]) due_q <= 1'b0;
        end
      end
    end

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        po_q <= '1;
        po_q.sclk <= 1'b0;
        po_q.dt <= 1'b0;
      end else begin
        po_q.sclk <= sclk_int_q;
        po_q.sclk_oe_n <= !ctrl_q[p].iclk; // R15
        po_q.rfs <= fs_gen[2 * p] ^ ctrl_q[p].inv[0]; // R05
        po_q.tfs <= fs_gen[2 * p + 1] ^ ctrl_q[p].inv[1]; // R05
        if (p == 1 && alt_q) begin
          po_q.rfs_oe_n <= 1'b1; // R13
          po_q.tfs_oe_n <= 1'b1;
          po_q.dt <= flag_out_q; // R14
          po_q.dt_oe_n <= 1'b0;
        end else begin
          po_q.rfs_oe_n <= !(ctrl_q[p].en && ctrl_q[p].fen[0] && ctrl_q[p].ifs[0]); // R04
          po_q.tfs_oe_n <= !(ctrl_q[p].en && ctrl_q[p].fen[1] && ctrl_q[p].ifs[1]); // R04
          po_q.dt <= dt_bit[2 * p + 1];
          po_q.dt_oe_n <= !dt_drv[2 * p + 1];
        end
      end
    end

    // d = 0 receive, d = 1 transmit; each section has its own shifter
    for (genvar d = 0; d < 2; d++) begin : g_sec
      localparam int unsigned S = 2 * p + d;
      ssp_sec_state_t st_q;
      logic [15:0] sh_q;
      logic [3:0] cnt_q;
      logic [4:0] slot_q;
      logic [7:0] ab_q;
      logic fs_q;
      logic full_q;
      logic [15:0] hold_q;
      logic ev_q;
      logic xfer_q;
      logic dt_q;
      logic drv_q;
      ssp_ctrl_t c;
      logic en;
      logic [3:0] n;
      logic mc;
      logic [31:0] mcm;
      logic fsb;
      logic start;
      logic wend;
      logic more;
      logic mc_more;
      logic [4:0] nxt_slot;
      logic load;
      logic [15:0] shifted;
      logic [15:0] tx_word;

      assign c = ctrl_q[p];
      assign en = c.en && !(p == 1 && alt_q); // R18
      assign n = eff_len(c, d); // R07
      assign mc = (p == 0) && c.mce; // R12
      assign mcm = (d == 1) ? mch_tx_q : mch_rx_q;
      assign fsb = c.ifs[d] ? fs_q : ((d == 1 ? sy[p].tfs : sy[p].rfs) ^ c.inv[d]); // R04
      assign start = fall[p] && st_q == SEC_IDLE && en &&
                     (c.fen[d] ? fsb : (d == 0 || full_q)); // R03
      assign wend = fall[p] && st_q == SEC_SHIFT && cnt_q == n;
      assign mc_more = mc && slot_q != (c.mc32 ? MC_LAST_32 : MC_LAST_24); // R12
      assign more = en && (!c.fen[d] || mc_more || (fsb && !c.late[d])) &&
                    (d == 0 || full_q || mc); // R06
      assign nxt_slot = (start || !mc_more) ? 5'h00 : slot_q + 5'h01;
      assign load = d == 1 && full_q && (start || (wend && more)) && (!mc || mcm[nxt_slot]);
      assign shifted = {sh_q[14:0], sy[p].dr};
      assign tx_word = is_cmp(c.cmp[d]) ? {8'h00, enc(hold_q, c.cmp[d][0])} : hold_q; // R08
      assign sec_ev[S] = ev_q;
      assign sec_full[S] = full_q;
      assign fs_gen[S] = fs_q;
      assign dt_bit[S] = dt_q;
      assign dt_drv[S] = drv_q;
      assign hold[S] = hold_q;
      assign abuf_req_q[S] = xfer_q;
      if (d == 0) begin : g_rxs
        assign rx_start[p] = start;
      end

      always_ff @(posedge sys_clk) begin
        if (srst) begin
          st_q <= SEC_IDLE;
          sh_q <= '0;
          cnt_q <= '0;
          slot_q <= '0;
        end else if (start) begin
          st_q <= SEC_SHIFT;
          slot_q <= 5'h00;
          if (c.late[d]) begin
            sh_q <= {(load ? tx_word[14:0] : 15'h0000), sy[p].dr}; // R06
            cnt_q <= 4'h1;
          end else begin
            sh_q <= load ? tx_word : 16'h0000;
            cnt_q <= 4'h0;
          end
        end else if (wend) begin
          if (more) begin
            sh_q <= load ? tx_word : 16'h0000;
            cnt_q <= 4'h0;
            slot_q <= nxt_slot;
          end else begin
            st_q <= SEC_IDLE;
          end
        end else if (fall[p] && st_q == SEC_SHIFT) begin
          sh_q <= shifted;
          cnt_q <= cnt_q + 4'h1;
        end else if (!en) begin
          st_q <= SEC_IDLE;
        end
      end

      // holding register: transmit buffer or received word
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          hold_q <= '0;
          full_q <= 1'b0;
        end else if (d == 1) begin
          if (bus_req.wr && hit(bus_req.addr, p, OFF_TXD)) begin
            hold_q <= bus_req.wdata[15:0];
            full_q <= 1'b1; // R01
          end else if (load) begin
            full_q <= 1'b0; // R01
          end
        end else begin
          if (wend && (!mc || mcm[slot_q])) begin
            hold_q <= is_cmp(c.cmp[d]) ? dec(shifted[7:0], c.cmp[d][0]) :
                      (shifted & wmask(n)); // R08
            full_q <= 1'b1; // R01
          end else if (bus_req.rd && hit(bus_req.addr, p, OFF_RXD)) begin
            full_q <= 1'b0;
          end
        end
      end

      // word and buffer completion events
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          ab_q <= '0;
          ev_q <= 1'b0;
          xfer_q <= 1'b0;
        end else begin
          ev_q <= 1'b0;
          xfer_q <= 1'b0;
          if (wend && (!mc || mcm[slot_q])) begin
            if (d == 1 ? c.ab_tx : c.ab_rx) begin
              xfer_q <= 1'b1; // R10
              if (ab_q == abuf_q[p][8 * d +: 8]) begin
                ab_q <= 8'h00;
                ev_q <= 1'b1; // R11
              end else begin
                ab_q <= ab_q + 8'h01; // R10
              end
            end else begin
              ev_q <= 1'b1; // R09
            end
          end
        end
      end

      // frame sync generation and data drive on rising serial clock edges
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          fs_q <= 1'b0;
          dt_q <= 1'b0;
          drv_q <= 1'b0;
        end else if (rise[p]) begin
          if (st_q == SEC_IDLE) begin
            fs_q <= en && (d == 1 ? full_q : frame_due[p]); // R04
          end else if (!c.wide[d]) begin
            fs_q <= 1'b0; // R06
          end
          dt_q <= (st_q == SEC_SHIFT) ? sh_q[n] : tx_word[n];
          drv_q <= en && (!mc || mcm[slot_q]) && (st_q == SEC_SHIFT || c.late[d]); // R12
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> logic/ssp_unused_placeholder_removed.sv
`default_nettype none
`default_nettype wire

// >>> tb/ssp_port_pair_sva.sv
`default_nettype none
module ssp_port_pair_sva
  import ssp_pkg::*;
#(
  parameter int unsigned DIV_W = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire ssp_bus_req_t bus_req,
  input wire logic [DW-1:0] rd_data_q,
  input wire ssp_pin_in_t [NPORT-1:0] pin_in,
  input wire ssp_pin_out_t [NPORT-1:0] pin_out_q,
  input wire logic irq_q,
  input wire logic [NSEC-1:0] abuf_req_q
);
  logic mode_q;
  logic [ST_W-1:0] mask_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // shadow of the second port mode bit
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_q <= 1'b0;
    end else if (bus_req.wr && bus_req.addr == OFF_SYSCTL) begin
      mode_q <= bus_req.wdata[0];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mask_q <= MASK_RST;
    end else if (bus_req.wr && bus_req.addr == OFF_MASK) begin
      mask_q <= bus_req.wdata[ST_W-1:0];
    end
  end
  sequence mask_off_s;
    bus_req.wr && bus_req.addr == OFF_MASK && bus_req.wdata[ST_W-1:0] == '0;
  endsequence
  sequence flag_wr_s;
    mode_q && bus_req.wr && bus_req.addr == OFF_FLAG;
  endsequence
  sequence clk_on_s;
    mode_q && bus_req.wr && bus_req.addr == (PORT_STRIDE | OFF_CTRL) && bus_req.wdata[5];
  endsequence
  rd_idle_zero_a: assert property (!bus_req.rd |=> rd_data_q == '0)
    else $error("read data not zero outside answer cycle");
  unmapped_read_a: assert property (bus_req.rd && bus_req.addr >= 6'h16 |=> rd_data_q == '0)
    else $error("unmapped read not zero");
  mask_readback_a: assert property (bus_req.rd && bus_req.addr == OFF_MASK
    |=> rd_data_q == {26'h0, mask_q}) else $error("mask read back wrong");
  mask_off_irq_a: assert property (mask_off_s |-> ##2 !irq_q)
    else $error("interrupt high with all sources masked");
  irq_cause_a: assert property ($rose(irq_q) |-> mask_q != '0)
    else $error("interrupt rose with mask empty");
  dt_on_rise_a: assert property ($changed(pin_out_q[0].dt) && !pin_out_q[0].dt_oe_n
    && $past(pin_out_q[0].dt_oe_n) == 1'b0 && !pin_out_q[0].sclk_oe_n
    |-> $rose(pin_out_q[0].sclk))
    else $error("transmit data moved off a serial clock rise");
  tfs_on_rise_a: assert property ($changed(pin_out_q[0].tfs) && !pin_out_q[0].tfs_oe_n
    && $past(pin_out_q[0].tfs_oe_n) == 1'b0 && !pin_out_q[0].sclk_oe_n
    |-> $rose(pin_out_q[0].sclk))
    else $error("frame sync moved off a serial clock rise");
  flag_out_a: assert property (flag_wr_s |-> ##2 pin_out_q[1].dt
    == $past(bus_req.wdata[FLG_OUT], 2) && !pin_out_q[1].dt_oe_n)
    else $error("flag output not driven from flag register");
  clock_kept_a: assert property (clk_on_s |-> ##2 !pin_out_q[1].sclk_oe_n)
    else $error("serial clock not driven in flag mode");
endmodule
bind ssp_port_pair ssp_port_pair_sva #(.DIV_W(DIV_W)) sva_u (.sys_clk(sys_clk), .srst(srst),
  .bus_req(bus_req), .rd_data_q(rd_data_q), .pin_in(pin_in), .pin_out_q(pin_out_q),
  .irq_q(irq_q), .abuf_req_q(abuf_req_q));
`default_nettype wire

// >>> tb/ssp_codec_model.sv
`default_nettype none
module ssp_codec_model
  import ssp_pkg::*;
(
  input wire ssp_pin_out_t pout,
  input wire logic [15:0] word,
  input wire logic [4:0] nbits,
  output ssp_pin_in_t pin,
  output logic [15:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sh = '0;
  logic dr = 1'b0;
  int tcnt = 0;
  int rcnt = 0;
  // released lines read low through pull-downs
  assign pin.sclk = !pout.sclk_oe_n && pout.sclk;
  assign pin.rfs = !pout.rfs_oe_n && pout.rfs;
  assign pin.tfs = !pout.tfs_oe_n && pout.tfs;
  assign pin.dr = dr;
  initial got = '0;
  // sample on fall, first bit one clock after frame sync
  always @(negedge pin.sclk) begin
    if (tcnt > 0) begin
      sh = {sh[14:0], pout.dt};
      tcnt--;
      if (tcnt == 0) got = sh;
    end
    if (pin.tfs) begin
      tcnt = nbits;
      sh = '0;
    end
    if (pin.rfs) rcnt = nbits;
  end
  // msb first on rise; outside a word the line keeps changing
  always @(posedge pin.sclk) begin
    if (rcnt > 0) begin
      dr = word[rcnt-1];
      rcnt--;
    end else begin
      dr = ~dr;
    end
  end
endmodule
`default_nettype wire

// >>> tb/ssp_port_pair_test.sv
`default_nettype none
module ssp_port_pair_test
  import ssp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  ssp_bus_req_t bus_req = '0;
  logic [DW-1:0] rd_data_q;
  wire ssp_pin_in_t [NPORT-1:0] pin_in;
  ssp_pin_out_t [NPORT-1:0] pin_out_q;
  ssp_pin_in_t p1_in = '{sclk: 1'b0, rfs: 1'b1, tfs: 1'b1, dr: 1'b0};
  logic irq_q;
  logic [NSEC-1:0] abuf_req_q;
  logic [15:0] far_word = '0;
  logic [4:0] far_bits = 5'h10;
  logic [15:0] far_got;
  int num_errors = 0;
  int total_checks = 0;
  int ab_cnt = 0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (abuf_req_q[1]) ab_cnt <= ab_cnt + 1;
  end
  assign pin_in[1] = p1_in;
  ssp_port_pair dut_u (.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req),
    .rd_data_q(rd_data_q), .pin_in(pin_in), .pin_out_q(pin_out_q), .irq_q(irq_q),
    .abuf_req_q(abuf_req_q));
  ssp_codec_model far_u (.pout(pin_out_q[0]), .word(far_word), .nbits(far_bits),
    .pin(pin_in[0]), .got(far_got));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus_req <= '0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 d = rd_data_q;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    logic [DW-1:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic wait_stat(input int b);
    logic [DW-1:0] s;
    s = '0;
    for (int n = 0; n < 500 && s[b] !== 1'b1; n++) rd(OFF_STAT, s);
    chk(32'(s[b]), 32'h1);
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #(100 * 8000);
    num_errors++;
    print_verdict();
  end
  initial begin
    logic [3:0] sl;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rdc(OFF_CTRL, CTRL_RST);
    rdc(OFF_SCLKDIV, 32'(SCLKDIV_RST));
    rdc(OFF_FSDIV, 32'(FSDIV_RST));
    rdc(OFF_STAT, 32'(STAT_RST));
    wr(6'h3F, 32'hFFFFFFFF);
    rdc(6'h3F, 32'h0);
    wr(OFF_MASK, 32'h3F);
    rdc(OFF_MASK, 32'h3F);
    for (int i = 0; i < 2; i++) begin
      sl = i ? 4'h2 : 4'hF;
      far_bits <= 5'(sl) + 5'h1;
      far_word <= i ? 16'h0005 : 16'h3C96;
      wr(OFF_CTRL, 32'h3F0 | 32'(sl));
      wr(OFF_TXD, i ? 32'h6 : 32'hA5C3);
      wait_stat(1);
      chk(32'(far_got), i ? 32'h6 : 32'hA5C3);
      chk(32'(irq_q), 32'h1);
      wait_stat(0);
      rdc(OFF_RXD, i ? 32'h5 : 32'h3C96);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_STAT, 32'h3F);
      rdc(OFF_STAT, 32'h0);
      chk(32'(irq_q), 32'h0);
    end
    far_bits <= 5'h08;
    wr(OFF_ABUF, 32'h100);
    wr(OFF_CTRL, 32'h8C02F7);
    wr(OFF_TXD, 32'h0);
    for (int n = 0; n < 500 && ab_cnt == 0; n++) @(posedge sys_clk);
    rdc(OFF_STAT, 32'h0);
    wr(OFF_TXD, 32'h0);
    wait_stat(1);
    chk(32'(far_got), 32'hD5);
    chk(ab_cnt, 32'h2);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_STAT, 32'h3F);
    p1_in.dr <= 1'b1;
    wr(OFF_SYSCTL, 32'h1);
    wr(PORT_STRIDE | OFF_CTRL, 32'h20);
    chk(32'(pin_out_q[1].sclk_oe_n), 32'h0);
    wr(OFF_FLAG, 32'h1);
    rdc(OFF_FLAG, 32'h3);
    chk(32'({pin_out_q[1].dt, pin_out_q[1].dt_oe_n}), 32'h2);
    p1_in.rfs <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rdc(OFF_STAT, 32'h10);
    p1_in.tfs <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rdc(OFF_STAT, 32'h30);
    chk(32'(irq_q), 32'h1);
    wr(OFF_MASK, 32'h0);
    chk(32'(irq_q), 32'h0);
    wr(OFF_STAT, 32'h30);
    rdc(OFF_STAT, 32'h0);
    wr(OFF_SYSCTL, 32'h0);
    rdc(OFF_SYSCTL, 32'h0);
    chk(32'(pin_out_q[1].dt_oe_n), 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
